// >>> design/system_clock_brownout_irq_control.sv
// apb system control: clocking, adc rate, brownout and interrupts
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module system_clock_brownout_irq_control
  import sysctl_pkg::*;
#(
  parameter logic [31:0] FLASH_BYTES = 32'h0001_0000,
  parameter logic [1:0] ADC_RATE_LIMIT = 2'h0 // fastest allowed rate
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic iosc_tick_in,
  input wire logic brownout_det_in,
  input wire logic pll_locked_in,
  input wire logic pll_fail_in,
  input wire logic overcurrent_in,
  input wire logic ldo_droop_in,
  input wire logic iosc_fail_det_in,
  input wire logic mosc_fail_det_in,
  input wire logic deep_sleep_in,
  input wire logic [NUM_PERIPH-1:0] periph_enable_in,
  input wire logic [NUM_PERIPH-1:0] periph_deep_enable_in,
  output logic [NUM_PERIPH-1:0] periph_clk_en_out,
  output logic [3:0] sysclk_div_out,
  output logic sysclk_use_pll_out,
  output logic [1:0] osc_source_out,
  output logic [3:0] xtal_select_out,
  output logic iosc_enable_out,
  output logic mosc_enable_out,
  output logic [1:0] adc_rate_out,
  output logic [2:0] pwm_div_out,
  output logic sys_irq_out,
  output logic brownout_reset_out
);
  // ==========================================================
  // apb access decode
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign rd_acc = psel_in && penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFS_PWM_DIV);
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_acc && (paddr_in == ofs);
  endfunction

  // ==========================================================
  // clock configuration
  clock_cfg_s clk_reg;
  clock_cfg_s clk_next;
  always_comb begin
    clk_next = clk_reg;
    if (hit(OFS_CLOCK_CFG)) begin
      clk_next.sysclk_divide_select = pwdata_in[CLK_DIV_LSB +: 4];
      clk_next.sysclk_from_oscillator = pwdata_in[CLK_USE_OSC_BIT];
      clk_next.xtal_select = pwdata_in[CLK_XTAL_LSB +: 4];
      // reserved code 3 keeps previous source
      if (pwdata_in[CLK_SRC_LSB +: 2] != 2'h3) begin
        clk_next.osc_source = pwdata_in[CLK_SRC_LSB +: 2];
      end
      clk_next.internal_osc_disable = pwdata_in[CLK_IOSC_DIS_BIT];
      clk_next.main_osc_disable = pwdata_in[CLK_MOSC_DIS_BIT];
    end
    // never stop the oscillator that feeds the system
    if (clk_next.osc_source == SOURCE_MAIN_OSCILLATOR) begin
      clk_next.main_osc_disable = 1'b0;
    end else begin
      clk_next.internal_osc_disable = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // reset word fields repacked into the struct's own field order
      clk_reg <= {CLOCK_CFG_RESET[CLK_DIV_LSB +: 4],
                  CLOCK_CFG_RESET[CLK_USE_OSC_BIT],
                  CLOCK_CFG_RESET[CLK_SRC_LSB +: 2],
                  CLOCK_CFG_RESET[CLK_XTAL_LSB +: 4],
                  CLOCK_CFG_RESET[CLK_IOSC_DIS_BIT],
                  CLOCK_CFG_RESET[CLK_MOSC_DIS_BIT]};
    end else begin
      clk_reg <= clk_next;
    end
  end
  // peripherals share sysclk; only the pwm divider is separate
  assign sysclk_div_out = clk_reg.sysclk_divide_select;
  assign sysclk_use_pll_out = !clk_reg.sysclk_from_oscillator;
  assign osc_source_out = clk_reg.osc_source;
  assign xtal_select_out = clk_reg.xtal_select;
  assign iosc_enable_out = !clk_reg.internal_osc_disable;
  assign mosc_enable_out = !clk_reg.main_osc_disable;

  // ==========================================================
  // pwm divider and adc rate
  logic [2:0] pwm_div_reg;
  logic [1:0] adc_req_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_div_reg <= PWM_DIV_RESET;
    end else if (hit(OFS_PWM_DIV)) begin
      pwm_div_reg <= pwdata_in[2:0];
    end
  end
  assign pwm_div_out = pwm_div_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_req_reg <= ADC_RATE_RESET;
    end else if (hit(OFS_ADC_RATE)) begin
      adc_req_reg <= pwdata_in[1:0];
    end
  end
  // larger code is slower; clamp to the hardware limit
  assign adc_rate_out = (adc_req_reg < ADC_RATE_LIMIT) ?
                        ADC_RATE_LIMIT : adc_req_reg;

  // ==========================================================
  // brownout detect with optional resample
  logic [12:0] bor_delay_reg;
  logic bor_reset_sel_reg;
  logic bor_resample_reg;
  bor_state_e bor_state_reg;
  logic [12:0] bor_cnt_reg;
  logic bor_event;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bor_delay_reg <= BOR_DELAY_RESET;
      bor_reset_sel_reg <= 1'b0;
      bor_resample_reg <= 1'b0;
    end else if (hit(OFS_BROWNOUT)) begin
      bor_delay_reg <= pwdata_in[BOR_DELAY_LSB +: 13];
      bor_reset_sel_reg <= pwdata_in[BOR_RESET_BIT];
      bor_resample_reg <= pwdata_in[BOR_RESAMPLE_BIT];
    end
  end
  // delay counts internal oscillator ticks, not system clocks
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bor_state_reg <= BOR_IDLE;
      bor_cnt_reg <= 13'h0000;
    end else begin
      case (bor_state_reg)
        BOR_IDLE: begin
          if (brownout_det_in) begin
            if (!bor_resample_reg) begin
              bor_state_reg <= BOR_HIT;
            end else begin
              bor_state_reg <= BOR_WAIT;
              bor_cnt_reg <= bor_delay_reg;
            end
          end
        end
        BOR_WAIT: begin
          if (bor_cnt_reg == 13'h0000) begin
            // second sample must also be active
            bor_state_reg <= brownout_det_in ? BOR_HIT : BOR_IDLE;
          end else if (iosc_tick_in) begin
            bor_cnt_reg <= bor_cnt_reg - 13'h0001;
          end
        end
        BOR_HIT: begin
          if (!brownout_det_in) begin
            bor_state_reg <= BOR_IDLE;
          end
        end
        default: bor_state_reg <= BOR_IDLE;
      endcase
    end
  end
  assign bor_event = (bor_state_reg == BOR_HIT);
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brownout_reset_out <= 1'b0;
    end else begin
      brownout_reset_out <= bor_event && bor_reset_sel_reg;
    end
  end

  // ==========================================================
  // clock verification status
  logic [2:0] ver_en_reg;
  logic [2:0] ver_stat_reg;
  logic [2:0] ver_fail;
  assign ver_fail = {pll_fail_in, mosc_fail_det_in, iosc_fail_det_in};
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ver_en_reg <= 3'h0;
    end else if (hit(OFS_VERIFY)) begin
      ver_en_reg <= pwdata_in[2:0];
    end
  end
  // writing a one to a status bit clears it; a new failure wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ver_stat_reg <= 3'h0;
    end else begin
      ver_stat_reg <= (ver_stat_reg & ~(hit(OFS_VERIFY) ?
                      pwdata_in[VER_STAT_LSB +: 3] : 3'h0))
                      | (ver_fail & ver_en_reg);
    end
  end

  // ==========================================================
  // deep-sleep peripheral gating
  logic sleep_gate_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_gate_reg <= 1'b0;
    end else if (hit(OFS_SLEEP_CFG)) begin
      sleep_gate_reg <= pwdata_in[SLEEP_GATE_BIT];
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_clk_en_out <= '0;
    end else if (deep_sleep_in && sleep_gate_reg) begin
      periph_clk_en_out <= periph_deep_enable_in;
    end else begin
      periph_clk_en_out <= periph_enable_in;
    end
  end

  // ==========================================================
  // interrupt flags, mask and output
  int_flags_s flags_reg;
  logic [NUM_INT-1:0] mask_reg;
  logic [NUM_INT-1:0] set_vec;
  logic [NUM_INT-1:0] clr_vec;
  logic pll_lock_d_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_lock_d_reg <= 1'b0;
    end else begin
      pll_lock_d_reg <= pll_locked_in;
    end
  end
  always_comb begin
    set_vec = '0;
    set_vec[INT_PLL_LOCK] = pll_locked_in && !pll_lock_d_reg;
    set_vec[INT_OVERCURRENT] = overcurrent_in;
    set_vec[INT_IOSC_FAIL] = iosc_fail_det_in && ver_en_reg[0];
    set_vec[INT_MOSC_FAIL] = mosc_fail_det_in && ver_en_reg[1];
    set_vec[INT_LDO_DROOP] = ldo_droop_in;
    // a brownout set for reset raises no flag
    set_vec[INT_SUPPLY_DROOP] = bor_event && !bor_reset_sel_reg;
    set_vec[INT_PLL_FAIL] = pll_fail_in && ver_en_reg[2];
  end
  // decoded in place: hidden reads inside a function never wake an assign
  assign clr_vec = (wr_acc && (paddr_in == OFS_INT_CLEAR)) ?
                   pwdata_in[NUM_INT-1:0] : '0;
  // set wins over a simultaneous clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_reg <= '0;
    end else begin
      flags_reg.raw <= (flags_reg.raw & ~clr_vec) | set_vec;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_reg <= '0;
    end else if (hit(OFS_INT_MASK)) begin
      mask_reg <= pwdata_in[NUM_INT-1:0];
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_irq_out <= 1'b0;
    end else begin
      sys_irq_out <= |(flags_reg.raw & mask_reg);
    end
  end

  // ==========================================================
  // read data, registered in the setup phase, valid in the access phase
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        OFS_CLOCK_CFG: prdata_out <= {18'h0, clk_reg.main_osc_disable,
          clk_reg.internal_osc_disable, clk_reg.xtal_select, 1'b0,
          clk_reg.osc_source, clk_reg.sysclk_from_oscillator,
          clk_reg.sysclk_divide_select};
        OFS_ADC_RATE: prdata_out <= {30'h0, adc_rate_out};
        OFS_BROWNOUT: prdata_out <= {17'h0, bor_resample_reg,
                                     bor_reset_sel_reg, bor_delay_reg};
        OFS_INT_RAW: prdata_out <= {25'h0, flags_reg.raw};
        OFS_INT_MASK: prdata_out <= {25'h0, mask_reg};
        OFS_INT_MASKED: prdata_out <= {25'h0,
                                       flags_reg.raw & mask_reg};
        OFS_VERIFY: prdata_out <= {21'h0, ver_stat_reg, 5'h0, ver_en_reg};
        OFS_SLEEP_CFG: prdata_out <= {31'h0, sleep_gate_reg};
        OFS_FLASH_SIZE: prdata_out <= FLASH_BYTES;
        OFS_PWM_DIV: prdata_out <= {29'h0, pwm_div_reg};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    |(flags_reg.raw & mask_reg) |=> sys_irq_out)
    else $error("irq missing for enabled flag");
  AST_IRQ_MASKED: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (mask_reg == '0) |=> !sys_irq_out)
    else $error("irq with all sources disabled");
  AST_CLEAR: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (clr_vec[0] && !set_vec[0])
      |=> !flags_reg.raw[0])
    else $error("flag not cleared");
  AST_LOCK_FLAG: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    $rose(pll_locked_in) |=> ##1 flags_reg.raw[INT_PLL_LOCK])
    else $error("pll lock flag not set");
  AST_ADC_LIMIT: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    adc_rate_out >= ADC_RATE_LIMIT && adc_rate_out >= adc_req_reg)
    else $error("adc rate above limit");
  AST_KEEP_OSC: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (osc_source_out == SOURCE_MAIN_OSCILLATOR) |-> mosc_enable_out)
    else $error("running oscillator disabled");
  AST_BOR_DIRECT: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (bor_state_reg == BOR_IDLE && brownout_det_in && !bor_resample_reg
     && bor_reset_sel_reg) |=> ##1 brownout_reset_out)
    else $error("brownout reset missing");
  AST_VERIFY_HOLD: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (ver_stat_reg[0] && !(wr_acc && (paddr_in == OFS_VERIFY)))
      |=> ver_stat_reg[0])
    else $error("verify status lost");
  AST_GATING: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (deep_sleep_in && sleep_gate_reg)
      |=> periph_clk_en_out == $past(periph_deep_enable_in))
    else $error("deep-sleep gating wrong");
  COV_IRQ: cover property (@(posedge ref_clk_in) $rose(sys_irq_out));
  COV_BOR_RESAMPLE: cover property (@(posedge ref_clk_in)
    bor_state_reg == BOR_WAIT ##[1:50] bor_state_reg == BOR_HIT);
  COV_BOR_RESET: cover property (@(posedge ref_clk_in)
    brownout_reset_out);
endmodule
`default_nettype wire

// >>> design/sysctl_pkg.sv
// constants, register map and carriers for the system control block
package sysctl_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CLOCK_CFG = 8'h00;
  localparam logic [7:0] OFS_ADC_RATE = 8'h04;
  localparam logic [7:0] OFS_BROWNOUT = 8'h08;
  localparam logic [7:0] OFS_INT_RAW = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_INT_MASKED = 8'h14;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h18;
  localparam logic [7:0] OFS_VERIFY = 8'h1C;
  localparam logic [7:0] OFS_SLEEP_CFG = 8'h20;
  localparam logic [7:0] OFS_FLASH_SIZE = 8'h24;
  localparam logic [7:0] OFS_PWM_DIV = 8'h28;
  // ==========================================================
  // clock config fields
  localparam int CLK_DIV_LSB = 0;   // 4 bits, divide = value + 1
  localparam int CLK_USE_OSC_BIT = 4;
  localparam int CLK_SRC_LSB = 5;   // 2 bits
  localparam int CLK_XTAL_LSB = 8;  // 4 bits
  localparam int CLK_IOSC_DIS_BIT = 12;
  localparam int CLK_MOSC_DIS_BIT = 13;
  localparam logic [31:0] CLOCK_CFG_RESET = 32'h0000_0010;
  // brownout fields
  localparam int BOR_DELAY_LSB = 0; // 13 bits
  localparam int BOR_RESET_BIT = 13;
  localparam int BOR_RESAMPLE_BIT = 14;
  // verify control/status fields
  localparam int VER_IOSC_EN_BIT = 0;
  localparam int VER_MOSC_EN_BIT = 1;
  localparam int VER_PLL_EN_BIT = 2;
  localparam int VER_STAT_LSB = 8;  // 3 status bits
  localparam int SLEEP_GATE_BIT = 0;
  // interrupt flag positions
  localparam int INT_PLL_LOCK = 0;
  localparam int INT_OVERCURRENT = 1;
  localparam int INT_IOSC_FAIL = 2;
  localparam int INT_MOSC_FAIL = 3;
  localparam int INT_LDO_DROOP = 4;
  localparam int INT_SUPPLY_DROOP = 5;
  localparam int INT_PLL_FAIL = 6;
  localparam int NUM_INT = 7;
  localparam int NUM_PERIPH = 32;
  localparam logic [12:0] BOR_DELAY_RESET = 13'h0000;
  localparam logic [1:0] ADC_RATE_RESET = 2'h0;
  localparam logic [2:0] PWM_DIV_RESET = 3'h0;
  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    RATE_1M = 2'b00, RATE_500K = 2'b01, RATE_250K = 2'b10,
    RATE_125K = 2'b11
  } adc_rate_select_e;
  typedef enum logic [1:0] {
    SOURCE_MAIN_OSCILLATOR = 2'b00, SOURCE_INTERNAL_OSCILLATOR = 2'b01,
    SOURCE_INTERNAL_DIV_FOUR = 2'b10
  } osc_source_e;
  typedef enum logic [1:0] {
    BOR_IDLE = 2'b00, BOR_WAIT = 2'b01, BOR_HIT = 2'b10
  } bor_state_e;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] sysclk_divide_select;
    logic sysclk_from_oscillator;
    logic [1:0] osc_source;
    logic [3:0] xtal_select;
    logic internal_osc_disable;
    logic main_osc_disable;
  } clock_cfg_s;
  typedef struct packed {
    logic [NUM_INT-1:0] raw;
  } int_flags_s;
endpackage

// >>> bench/tb_system_clock_brownout_irq_control.sv
// self-checking bench for the apb system control block
`timescale 1ns/100ps
`default_nettype none
module tb_system_clock_brownout_irq_control;
  import sysctl_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] el;
  } row_s;
  // ==========================================================
  // signals, named as the ports so both instances bind by name
  logic ref_clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, prdata_lim, rd, rdl;
  logic pready_out, pslverr_out, iosc_tick_in, brownout_det_in, err;
  logic pll_locked_in, pll_fail_in, overcurrent_in, ldo_droop_in;
  logic iosc_fail_det_in, mosc_fail_det_in, deep_sleep_in;
  logic [NUM_PERIPH-1:0] periph_enable_in, periph_deep_enable_in;
  logic [NUM_PERIPH-1:0] periph_clk_en_out;
  logic [3:0] sysclk_div_out, xtal_select_out;
  logic sysclk_use_pll_out, iosc_enable_out, mosc_enable_out;
  logic sys_irq_out, brownout_reset_out;
  logic [1:0] osc_source_out, adc_rate_out, adc_lim, tick_cnt;
  logic [2:0] pwm_div_out;
  int err_total, n_tests, cyc, i, k;
  // ordinary cases: address, write data, readback, limited readback
  row_s rows [14] = '{
    '{OFS_CLOCK_CFG, 32'h0000_0A4F, 32'h0000_0A4F, 32'h0000_0A4F},
    '{OFS_CLOCK_CFG, 32'h0000_0430, 32'h0000_0430, 32'h0000_0430},
    '{OFS_ADC_RATE, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002},
    '{OFS_ADC_RATE, 32'h0000_0001, 32'h0000_0001, 32'h0000_0002},
    '{OFS_ADC_RATE, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002},
    '{OFS_ADC_RATE, 32'h0000_0003, 32'h0000_0003, 32'h0000_0003},
    '{OFS_BROWNOUT, 32'h0000_1FFF, 32'h0000_1FFF, 32'h0000_1FFF},
    '{OFS_INT_MASK, 32'h0000_007F, 32'h0000_007F, 32'h0000_007F},
    '{OFS_INT_MASK, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
    '{OFS_PWM_DIV, 32'h0000_0007, 32'h0000_0007, 32'h0000_0007},
    '{OFS_SLEEP_CFG, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001},
    '{OFS_FLASH_SIZE, 32'h0000_0000, 32'h0001_0000, 32'h0001_0000},
    '{OFS_INT_RAW, 32'h0000_007F, 32'h0000_0000, 32'h0000_0000},
    '{OFS_INT_MASKED, 32'h0000_007F, 32'h0000_0000, 32'h0000_0000}
  };
  // ==========================================================
  // instances: second one has the adc rate capped at 250k
  system_clock_brownout_irq_control u_system_clock_brownout_irq_control (.*);
  system_clock_brownout_irq_control #(
    .ADC_RATE_LIMIT(2'h2)
  ) u_system_clock_brownout_irq_control_lim (
    .*, .prdata_out(prdata_lim), .pready_out(), .pslverr_out(),
    .periph_clk_en_out(), .sysclk_div_out(), .sysclk_use_pll_out(),
    .osc_source_out(), .xtal_select_out(), .iosc_enable_out(),
    .mosc_enable_out(), .adc_rate_out(adc_lim), .pwm_div_out(),
    .sys_irq_out(), .brownout_reset_out()
  );
  // ==========================================================
  // clock, oscillator tick every fourth cycle, hang guard
  initial ref_clk_in = 1'b0;
  always #10 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    tick_cnt <= tick_cnt + 2'h1;
    iosc_tick_in <= (tick_cnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    rdl = prdata_lim;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(nm, e, rd);
  endtask
  // sources in flag order, brownout detector on the supply droop slot
  task automatic set_src(input logic [6:0] v);
    @(posedge ref_clk_in);
    pll_locked_in <= v[0];
    overcurrent_in <= v[1];
    iosc_fail_det_in <= v[2];
    mosc_fail_det_in <= v[3];
    ldo_droop_in <= v[4];
    brownout_det_in <= v[5];
    pll_fail_in <= v[6];
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {psel_in, penable_in, pwrite_in, rst_n_in, deep_sleep_in} = '0;
    {paddr_in, pwdata_in, tick_cnt, cyc, err_total, n_tests} = '0;
    {iosc_tick_in, brownout_det_in, pll_locked_in, pll_fail_in} = '0;
    {overcurrent_in, ldo_droop_in, iosc_fail_det_in} = '0;
    mosc_fail_det_in = 1'b0;
    periph_enable_in = 32'hA5A5_0F0F;
    periph_deep_enable_in = 32'h0000_00FF;
    wait_cyc(2);
    rst_n_in <= 1'b1;
    // reset values
    wait_cyc(1);
    chk_bit("use pll", 1'b0, sysclk_use_pll_out);
    chk_bit("iosc en", 1'b1, iosc_enable_out);
    chk_bit("mosc en", 1'b1, mosc_enable_out);
    chk_bit("irq", 1'b0, sys_irq_out);
    rdchk("clock cfg", OFS_CLOCK_CFG, CLOCK_CFG_RESET);
    rdchk("adc rate", OFS_ADC_RATE, {30'h0, ADC_RATE_RESET});
    chk_word("capped rate", 32'h0000_0002, rdl);
    $display("test reset done");
    // register table
    for (i = 0; i < 14; i++) begin
      wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk_word("readback", rows[i].e, rd);
      chk_word("capped readback", rows[i].el, rdl);
      chk_bit("slverr", 1'b0, err);
    end
    chk_word("div", 32'h0, sysclk_div_out);
    chk_bit("use pll", 1'b0, sysclk_use_pll_out);
    chk_word("xtal", 32'h4, xtal_select_out);
    chk_word("adc", 32'h3, adc_rate_out);
    chk_word("pwm div", 32'h7, pwm_div_out);
    $display("test table done");
    // clock select, refused source code, running oscillator kept on
    wr(OFS_CLOCK_CFG, 32'h0000_0A4F);
    wr(OFS_CLOCK_CFG, 32'h0000_0A6F);
    wait_cyc(1);
    chk_word("div", 32'hF, sysclk_div_out);
    chk_bit("use pll", 1'b1, sysclk_use_pll_out);
    chk_word("source kept", 32'h2, osc_source_out);
    for (k = 0; k < 3; k++) begin
      wr(OFS_CLOCK_CFG, 32'h0000_3010 | (k << CLK_SRC_LSB));
      wait_cyc(2);
      chk_word("source", k, osc_source_out);
      chk_bit("iosc en", k != 0, iosc_enable_out);
      chk_bit("mosc en", k == 0, mosc_enable_out);
    end
    wr(OFS_ADC_RATE, 32'h0000_0000);
    wait_cyc(1);
    chk_word("capped adc", 32'h2, adc_lim);
    $display("test clock done");
    // deep-sleep gating
    deep_sleep_in <= 1'b1;
    wait_cyc(3);
    chk_word("gated", 32'h0000_00FF, periph_clk_en_out);
    wr(OFS_SLEEP_CFG, 32'h0);
    wait_cyc(2);
    chk_word("ungated", 32'hA5A5_0F0F, periph_clk_en_out);
    deep_sleep_in <= 1'b0;
    wr(OFS_SLEEP_CFG, 32'h1);
    wait_cyc(2);
    chk_word("run", 32'hA5A5_0F0F, periph_clk_en_out);
    $display("test sleep done");
    // each source flags alone, masked off, cleared by a write to the clear register
    wr(OFS_BROWNOUT, 32'h0);
    wr(OFS_VERIFY, 32'h7);
    for (i = 0; i < NUM_INT; i++) begin
      set_src(7'h1 << i);
      wait_cyc(6);
      set_src(7'h0);
      wait_cyc(2);
      rdchk("raw", OFS_INT_RAW, 32'h1 << i);
      rdchk("masked", OFS_INT_MASKED, 32'h0);
      chk_bit("irq masked", 1'b0, sys_irq_out);
      wr(OFS_INT_CLEAR, 32'h1 << i);
      rdchk("cleared", OFS_INT_RAW, 32'h0);
    end
    rdchk("verify", OFS_VERIFY, 32'h0000_0707);
    wr(OFS_VERIFY, 32'h0000_0707);
    rdchk("verify clr", OFS_VERIFY, 32'h0000_0007);
    set_src(7'h04);
    wait_cyc(4);
    set_src(7'h0);
    rdchk("verify again", OFS_VERIFY, 32'h0000_0107);
    wr(OFS_INT_CLEAR, 32'h7F);
    // enabled source reaches the processor line
    wr(OFS_INT_MASK, 32'h7F);
    set_src(7'h02);
    wait_cyc(4);
    set_src(7'h0);
    wait_cyc(2);
    chk_bit("irq", 1'b1, sys_irq_out);
    rdchk("masked", OFS_INT_MASKED, 32'h2);
    wr(OFS_INT_MASK, 32'h8);
    wait_cyc(2);
    chk_bit("irq off", 1'b0, sys_irq_out);
    wr(OFS_INT_MASK, 32'h2);
    wait_cyc(2);
    chk_bit("irq on", 1'b1, sys_irq_out);
    wr(OFS_INT_CLEAR, 32'h2);
    wait_cyc(2);
    chk_bit("irq cleared", 1'b0, sys_irq_out);
    $display("test interrupt done");
    // brownout with reset selected, direct then resampled
    wr(OFS_BROWNOUT, 32'h0000_2000);
    set_src(7'h20);
    wait_cyc(4);
    chk_bit("bor reset", 1'b1, brownout_reset_out);
    rdchk("no flag", OFS_INT_RAW, 32'h0);
    set_src(7'h0);
    wait_cyc(4);
    chk_bit("bor released", 1'b0, brownout_reset_out);
    wr(OFS_BROWNOUT, 32'h0000_6014);
    set_src(7'h20);
    wait_cyc(2);
    set_src(7'h0);
    wait_cyc(120);
    chk_bit("glitch", 1'b0, brownout_reset_out);
    set_src(7'h20);
    k = 0;
    while (brownout_reset_out !== 1'b1 && k < 200) begin
      @(posedge ref_clk_in);
      k++;
    end
    chk_bit("resampled", 1'b1, brownout_reset_out);
    chk_bit("delay", 1'b1, k >= 70 && k <= 90);
    set_src(7'h0);
    $display("test brownout done");
    // refused addresses
    apb(1'b1, 8'h2C, 32'hFFFF_FFFF);
    chk_bit("slverr wr", 1'b1, err);
    apb(1'b0, 8'h2C, 32'h0);
    chk_bit("slverr rd", 1'b1, err);
    chk_word("unmapped", 32'h0, rd);
    apb(1'b0, 8'h05, 32'h0);
    chk_bit("slverr align", 1'b1, err);
    $display("test refused done");
    // reset in mid-run
    wr(OFS_CLOCK_CFG, 32'h0000_0A4F);
    rst_n_in <= 1'b0;
    wait_cyc(2);
    chk_bit("use pll rst", 1'b0, sysclk_use_pll_out);
    chk_word("div rst", 32'h0, sysclk_div_out);
    rst_n_in <= 1'b1;
    rdchk("clock cfg rst", OFS_CLOCK_CFG, CLOCK_CFG_RESET);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
